// ---- rtl/flash_erase_pkg.sv ----
// Package: command codes, addresses and timing counts for the block erase host
package flash_erase_pkg;
  localparam int          ADDR_W          = 19;
  localparam logic [18:0] UNLOCK_ADDR_A   = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR_B   = 19'h02aaa;
  localparam logic [7:0]  UNLOCK_DATA_A   = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA_B   = 8'h55;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_BLK_CONFIRM = 8'h30;
  localparam logic [7:0]  CMD_READ_RESET  = 8'hf0;
  localparam int          ERASED_BYTE     = 8'hff;
  localparam int          PREPROG_BYTE    = 8'h00;
  // Status bit positions in the status byte
  localparam int          POLL_BIT_POS    = 7;
  localparam int          FAIL_BIT_POS    = 5;
  localparam int          TIMER_BIT_POS   = 3;
  // Write and read cycle timing, 150 ns grade
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          T_WP_NS         = 50;
  localparam int          T_WPH_NS        = 35;
  localparam int          T_AS_NS         = 0;
  localparam int          T_RD_NS         = 150;
  localparam int          WP_CYC  = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WPH_CYC = (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          AS_CYC  = (T_AS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1
                                    ? 1 : (T_AS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          RD_CYC  = (T_RD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W   = 8;
endpackage : flash_erase_pkg

// ---- rtl/flash_bus_cycle.sv ----
// Single flash bus cycle engine: one write or one read with strobe timing
`timescale 1ns/100ps
module flash_bus_cycle
  import flash_erase_pkg::*;
(
  input  wire logic              ref_clk,   // 200 MHz clock
  input  wire logic              rst_n,     // Sync reset, active low
  input  wire logic              start,     // Begin a cycle
  input  wire logic              is_write,  // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] addr,      // Cycle address
  input  wire logic [7:0]        wdata,     // Write data
  output logic                   done,      // Cycle finished pulse
  output logic [7:0]             rdata,     // Captured read byte
  output logic [ADDR_W-1:0]      fl_addr,   // Flash address pins
  output logic                   fl_ce_n,   // Chip enable
  output logic                   fl_oe_n,   // Output enable
  output logic                   fl_we_n,   // Write enable
  output logic [7:0]             dq_out,    // Data pins driven
  output logic                   dq_oe_n,   // Data drive enable, low drives
  input  wire logic [7:0]        dq_in      // Data pins sampled
);
  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_SETUP = 4'b0010,
    C_STRB  = 4'b0100,
    C_HOLD  = 4'b1000
  } cyc_state_t;

  typedef struct packed {
    cyc_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic              wr;
    logic              done;
    logic [7:0]        rdata;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } cyc_reg_t;

  cyc_reg_t r_ff, nxt_r;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    unique case (r_ff.st)
      C_IDLE: begin
        if (start) begin
          nxt_r.st    = C_SETUP;
          nxt_r.wr    = is_write;
          nxt_r.addr  = addr;
          nxt_r.wdata = wdata;
          nxt_r.cnt   = CNT_W'(AS_CYC - 1);
        end
      end
      C_SETUP: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st  = C_STRB;
          nxt_r.cnt = r_ff.wr ? CNT_W'(WP_CYC - 1) : CNT_W'(RD_CYC - 1);
        end else nxt_r.cnt = r_ff.cnt - 1'b1;
      end
      C_STRB: begin
        if (r_ff.cnt == '0) begin
          // Data latched by the flash on the rising write strobe
          nxt_r.st  = C_HOLD;
          nxt_r.cnt = CNT_W'(WPH_CYC - 1);
          if (!r_ff.wr) nxt_r.rdata = dq_in;
        end else nxt_r.cnt = r_ff.cnt - 1'b1;
      end
      C_HOLD: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st   = C_IDLE;
          nxt_r.done = 1'b1;
        end else nxt_r.cnt = r_ff.cnt - 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_ff <= '{st: C_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign done    = r_ff.done;
  assign rdata   = r_ff.rdata;
  assign fl_addr = r_ff.addr;
  assign fl_ce_n = (r_ff.st == C_IDLE);
  assign fl_we_n = !(r_ff.wr && r_ff.st == C_STRB);
  assign fl_oe_n = !(!r_ff.wr && r_ff.st == C_STRB);
  assign dq_out  = r_ff.wdata;
  // Keep driving through hold so data stays valid past the strobe edge
  assign dq_oe_n = !(r_ff.wr && r_ff.st != C_IDLE);
endmodule : flash_bus_cycle

// ---- rtl/flash_block_erase_sequencer.sv ----
// Host-side sequencer issuing multi-block erase to a parallel NOR flash
//
// Contract
// - Six writes minimum: two unlocks, then erase set-up 80h at 5555h.
// - Two more unlocks, then block confirm 30h as the sixth write.
// - Confirm write carries an address inside the block to erase.
// - Erase starts at timeout expiry; extra confirms must come before it.
`timescale 1ns/100ps
module flash_block_erase_sequencer
  import flash_erase_pkg::*;
#(
  parameter int MAX_BLOCKS = 8  // Blocks accepted per erase request
)(
  input  wire logic              ref_clk,     // 200 MHz clock
  input  wire logic              rst_n,       // Sync reset, active low
  input  wire logic              req_valid,   // Erase request / block address
  output logic                   req_ready,   // Block address accepted
  input  wire logic [ADDR_W-1:0] req_addr,    // Address inside target block
  input  wire logic              req_last,    // Final block of this request
  output logic                   busy,        // Erase sequence in progress
  output logic                   done,        // Sequence finished pulse
  output logic                   failed,      // Erase failed, held until next
  output logic [7:0]             status_byte, // Last status read
  output logic [ADDR_W-1:0]      fl_addr,     // Flash address pins
  output logic                   fl_ce_n,     // Chip enable
  output logic                   fl_oe_n,     // Output enable
  output logic                   fl_we_n,     // Write enable
  output logic [7:0]             dq_out,      // Data pins driven
  output logic                   dq_oe_n,     // Data drive enable, low drives
  input  wire logic [7:0]        dq_in        // Data pins sampled
);
  // -------------------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------------------
  // Block count is eight bits wide, so larger requests would wrap
  if (MAX_BLOCKS < 1 || MAX_BLOCKS > 255) begin : g_bad_max_blocks
    $error("MAX_BLOCKS out of range");
  end

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE    = 8'b0000_0001,
    S_UNLOCK  = 8'b0000_0010,
    S_CONFIRM = 8'b0000_0100,
    S_WAIT    = 8'b0000_1000,
    S_POLL    = 8'b0001_0000,
    S_CHECK   = 8'b0010_0000,
    S_RESET   = 8'b0100_0000,
    S_FINISH  = 8'b1000_0000
  } seq_state_t;

  typedef struct packed {
    seq_state_t        st;
    logic [2:0]        step;
    logic [7:0]        nblk;
    logic              last;
    logic              go;
    logic              is_wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic              done;
    logic              failed;
    logic [7:0]        status;
  } seq_reg_t;

  seq_reg_t r_ff, nxt_r;
  logic       cyc_done;
  logic [7:0] cyc_rdata;

  // -------------------------------------------------------------------------
  // Command pattern helpers
  // -------------------------------------------------------------------------
  // Fixed unlock plus set-up pattern, five writes before the first confirm
  function automatic logic [ADDR_W+7:0] unlock_word(input logic [2:0] idx);
    unique case (idx)
      3'd0, 3'd3: unlock_word = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
      3'd1, 3'd4: unlock_word = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
      default:    unlock_word = {UNLOCK_ADDR_A, CMD_ERASE_SETUP};
    endcase
  endfunction : unlock_word

  function automatic logic bit_of(input logic [7:0] b, input int pos);
    bit_of = b[pos];
  endfunction : bit_of

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.go   = 1'b0;
    nxt_r.done = 1'b0;
    req_ready  = 1'b0;
    unique case (r_ff.st)
      S_IDLE: begin
        if (req_valid) begin
          nxt_r.st     = S_UNLOCK;
          nxt_r.step   = 3'd0;
          nxt_r.nblk   = '0;
          nxt_r.failed = 1'b0;
          nxt_r.go     = 1'b1;
          nxt_r.is_wr  = 1'b1;
          {nxt_r.addr, nxt_r.data} = unlock_word(3'd0);
        end
      end
      S_UNLOCK: begin
        if (cyc_done) begin
          if (r_ff.step == 3'd4) begin
            nxt_r.st = S_CONFIRM;
          end else begin
            nxt_r.step = r_ff.step + 3'd1;
            nxt_r.go   = 1'b1;
            {nxt_r.addr, nxt_r.data} = unlock_word(r_ff.step + 3'd1);
          end
        end
      end
      S_CONFIRM: begin
        // Confirms issued back to back keep inside the device timeout
        req_ready = req_valid;
        if (req_valid) begin
          nxt_r.st    = S_WAIT;
          nxt_r.go    = 1'b1;
          nxt_r.is_wr = 1'b1;
          nxt_r.addr  = req_addr;
          nxt_r.data  = CMD_BLK_CONFIRM;
          nxt_r.nblk  = r_ff.nblk + 8'd1;
          nxt_r.last  = req_last || (r_ff.nblk + 8'd1 == 8'(MAX_BLOCKS));
        end
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (r_ff.last) begin
            nxt_r.st    = S_POLL;
            nxt_r.go    = 1'b1;
            nxt_r.is_wr = 1'b0;
          end else begin
            nxt_r.st = S_CONFIRM;
          end
        end
      end
      S_POLL: begin
        // Status reads until polling bit completes or failure bit sets; timer bit low means pending
        if (cyc_done) begin
          nxt_r.status = cyc_rdata;
          nxt_r.st     = S_CHECK;
        end
      end
      S_CHECK: begin
        if (bit_of(r_ff.status, POLL_BIT_POS) == 1'b1) begin
          nxt_r.st = S_FINISH;
        end else if (bit_of(r_ff.status, FAIL_BIT_POS)) begin
          nxt_r.failed = 1'b1;
          nxt_r.st     = S_RESET;
          nxt_r.go     = 1'b1;
          nxt_r.is_wr  = 1'b1;
          nxt_r.addr   = '0;
          nxt_r.data   = CMD_READ_RESET;
        end else begin
          // No other command during timeout or erase
          nxt_r.st    = S_POLL;
          nxt_r.go    = 1'b1;
          nxt_r.is_wr = 1'b0;
        end
      end
      S_RESET: begin
        if (cyc_done) nxt_r.st = S_FINISH;
      end
      S_FINISH: begin
        nxt_r.done = 1'b1;
        nxt_r.st   = S_IDLE;
      end
      default: nxt_r.st = S_IDLE;
    endcase
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_ff <= '{st: S_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // -------------------------------------------------------------------------
  // Bus cycle engine
  // -------------------------------------------------------------------------
  flash_bus_cycle u_cycle (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (r_ff.go),
    .is_write (r_ff.is_wr),
    .addr     (r_ff.addr),
    .wdata    (r_ff.data),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .fl_addr  (fl_addr),
    .fl_ce_n  (fl_ce_n),
    .fl_oe_n  (fl_oe_n),
    .fl_we_n  (fl_we_n),
    .dq_out   (dq_out),
    .dq_oe_n  (dq_oe_n),
    .dq_in    (dq_in)
  );

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign busy        = (r_ff.st != S_IDLE);
  assign done        = r_ff.done;
  assign failed      = r_ff.failed;
  assign status_byte = r_ff.status;
endmodule : flash_block_erase_sequencer

// ---- test/flash_erase_assertions.sv ----
// Port checks for the block erase sequencer
`timescale 1ns/100ps
module flash_erase_assertions
  import flash_erase_pkg::*;
#(
  parameter int MAX_BLOCKS = 8  // Blocks per request
)(
  input wire logic              ref_clk,     // Clock
  input wire logic              rst_n,       // Sync reset
  input wire logic              req_valid,   // Request
  input wire logic              req_ready,   // Address taken
  input wire logic [ADDR_W-1:0] req_addr,    // Block address
  input wire logic              done,        // End pulse
  input wire logic              failed,      // Failure flag
  input wire logic [7:0]        status_byte, // Last status
  input wire logic [ADDR_W-1:0] fl_addr,     // Flash address
  input wire logic              fl_ce_n,     // Chip enable
  input wire logic              fl_oe_n,     // Output enable
  input wire logic              fl_we_n,     // Write enable
  input wire logic [7:0]        dq_out,      // Write data
  input wire logic              dq_oe_n      // Drive enable
);
  logic [ADDR_W-1:0] blk_ff;
  logic [7:0]        cnt_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Count resets between requests so one long run cannot mask an overflow
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (done && !req_ready)) cnt_ff <= 8'h00;
    else if (req_ready && req_valid) cnt_ff <= cnt_ff + 8'h01;
    if (req_ready && req_valid) blk_ff <= req_addr;
  end
  AST_WR_DRIVE: assert property (!fl_we_n |-> !fl_ce_n && !dq_oe_n && fl_oe_n)
    else $error("write strobe without chip enable or data drive");
  AST_WP_LEN: assert property ($fell(fl_we_n) |-> ##9 !fl_we_n ##1 fl_we_n)
    else $error("write strobe width wrong");
  AST_WR_STABLE: assert property (
    !fl_we_n && !$past(fl_we_n) |-> $stable(fl_addr) && $stable(dq_out))
    else $error("address or data moved during write strobe");
  AST_SETUP_ADDR: assert property (
    $fell(fl_we_n) && dq_out == CMD_ERASE_SETUP |-> fl_addr == UNLOCK_ADDR_A)
    else $error("set-up command at wrong address");
  AST_UNLOCK_ADDR: assert property (
    $fell(fl_we_n) && dq_out == UNLOCK_DATA_B |-> fl_addr == UNLOCK_ADDR_B)
    else $error("second unlock at wrong address");
  AST_CONFIRM: assert property (
    req_ready && req_valid |-> ##[1:6]
      ($fell(fl_we_n) && dq_out == CMD_BLK_CONFIRM && fl_addr == blk_ff))
    else $error("confirm write missing or misaddressed");
  AST_MAX_BLK: assert property (cnt_ff <= MAX_BLOCKS)
    else $error("too many blocks in one request");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_OK_POLL: assert property (done && !failed |-> status_byte[POLL_BIT_POS])
    else $error("done before polling bit set");
  AST_FAIL_BIT: assert property (
    done && failed |-> status_byte[FAIL_BIT_POS] && !status_byte[POLL_BIT_POS])
    else $error("failure flagged without failure bit");
  AST_READ_BUS: assert property (!fl_oe_n |-> dq_oe_n && fl_we_n && !fl_ce_n)
    else $error("read with data drive or write strobe");
endmodule : flash_erase_assertions
bind flash_block_erase_sequencer flash_erase_assertions #(.MAX_BLOCKS(MAX_BLOCKS)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .req_addr(req_addr), .done(done), .failed(failed), .status_byte(status_byte),
  .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ---- test/flash_dev_model.sv ----
// Behavioural flash device answering the block erase sequence
`timescale 1ns/100ps
module flash_dev_model
  import flash_erase_pkg::*;
#(
  parameter int TMO_CYC = 100  // Erase timeout, shortened
)(
  input  wire logic              ref_clk,   // Sampling clock
  input  wire logic              rst_n,     // Power-on clear
  input  wire logic              fail_en,   // Report failed erase
  input  wire logic [15:0]       erase_cyc, // Erase duration
  input  wire logic [ADDR_W-1:0] fl_addr,   // Address pins
  input  wire logic              fl_ce_n,   // Chip enable
  input  wire logic              fl_oe_n,   // Output enable
  input  wire logic              fl_we_n,   // Write enable
  input  wire logic [7:0]        dq_out,    // Host data
  input  wire logic              dq_oe_n,   // Host drive, low drives
  output logic [7:0]             dq_in      // Data wire level
);
  typedef enum logic [1:0] {M_IDLE, M_TMO, M_ERASE, M_FAIL} mode_t;
  mode_t             st      = M_IDLE;
  logic              we_q    = 1'b1;
  logic              seq_err = 1'b0;
  logic [2:0]        wcnt    = 3'd0;
  logic [15:0]       tmr     = 16'h0000;
  logic [7:0]        stat;
  logic [7:0]        rd_q    = 8'h00;
  logic [ADDR_W-1:0] blk_q[$];
  function automatic logic pat_ok(logic [2:0] n, logic [ADDR_W-1:0] a, logic [7:0] d);
    case (n)
      3'd0, 3'd3: return a == UNLOCK_ADDR_A && d == UNLOCK_DATA_A;
      3'd1, 3'd4: return a == UNLOCK_ADDR_B && d == UNLOCK_DATA_B;
      3'd2:       return a == UNLOCK_ADDR_A && d == CMD_ERASE_SETUP;
      default:    return d == CMD_BLK_CONFIRM;
    endcase
  endfunction : pat_ok
  always_comb begin
    case (st)
      M_TMO:   stat = 8'h00;
      M_ERASE: stat = 8'h08;
      M_FAIL:  stat = 8'h28;
      default: stat = 8'hff;
    endcase
  end
  // Released wire shows the inverse of the last byte, never a stale copy
  assign dq_in = !dq_oe_n ? dq_out : (!fl_ce_n && !fl_oe_n) ? stat : ~rd_q;
  always @(posedge ref_clk) begin
    we_q <= fl_we_n;
    if (!fl_ce_n && !fl_oe_n) rd_q <= stat;
    if (!rst_n) begin
      st   <= M_IDLE;
      wcnt <= 3'd0;
    end else if (fl_we_n && !we_q && !fl_ce_n) begin
      if (st == M_ERASE || st == M_FAIL) begin
        if (dq_out == CMD_READ_RESET) st <= M_IDLE;
      end else if (st == M_TMO && dq_out == CMD_BLK_CONFIRM) begin
        blk_q.push_back(fl_addr);
        tmr <= 16'h0000;
      end else if (st == M_IDLE && pat_ok(wcnt, fl_addr, dq_out)) begin
        wcnt <= (wcnt == 3'd5) ? 3'd0 : wcnt + 3'd1;
        if (wcnt == 3'd5) begin
          blk_q.push_back(fl_addr);
          st  <= M_TMO;
          tmr <= 16'h0000;
        end
      end else begin
        seq_err <= 1'b1;
        wcnt    <= 3'd0;
        st      <= M_IDLE;
      end
    end else if (st == M_TMO && tmr >= TMO_CYC) begin
      st  <= M_ERASE;
      tmr <= 16'h0000;
    end else if (st == M_ERASE && tmr >= erase_cyc) begin
      st <= fail_en ? M_FAIL : M_IDLE;
    end else begin
      tmr <= tmr + 16'h0001;
    end
  end
endmodule : flash_dev_model

// ---- test/testbench.sv ----
// Self-checking bench for the block erase sequencer
`timescale 1ns/100ps
module testbench;
  import flash_erase_pkg::*;
  localparam int NBLK = 4;
  logic              ref_clk   = 1'b0;
  logic              rst_n     = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_last  = 1'b0;
  logic              fail_en   = 1'b0;
  logic [ADDR_W-1:0] req_addr  = '0;
  logic [15:0]       erase_cyc = 16'h0020;
  logic              req_ready, busy, done, failed, fl_ce_n, fl_oe_n, fl_we_n, dq_oe_n;
  logic [7:0]        status_byte, dq_out, dq_in;
  logic [ADDR_W-1:0] fl_addr;
  int                err_count = 0;
  int                samples_checked = 0;
  int                seed = 32'hc9f6;
  flash_block_erase_sequencer #(.MAX_BLOCKS(NBLK)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_last(req_last), .busy(busy), .done(done), .failed(failed),
    .status_byte(status_byte), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  flash_dev_model dev (
    .ref_clk(ref_clk), .rst_n(rst_n), .fail_en(fail_en), .erase_cyc(erase_cyc),
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  function automatic logic [7:0] exp_status(bit fail);
    return fail ? 8'((1 << FAIL_BIT_POS) | (1 << TIMER_BIT_POS)) : 8'(ERASED_BYTE);
  endfunction : exp_status
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Next address goes out only after the edge that took the previous one
  task automatic run_erase(int n, bit use_last, bit fail);
    logic [ADDR_W-1:0] a[NBLK];
    int                i;
    bit                hs;
    bit                seen;
    foreach (a[k]) a[k] = ADDR_W'($random(seed));
    dev.blk_q.delete();
    fail_en   = fail;
    erase_cyc = 16'(20 + {$random(seed)} % 200);
    req_valid = 1'b1;
    req_addr  = a[0];
    req_last  = use_last && n == 1;
    hs        = 1'b0;
    seen      = 1'b0;
    i         = 0;
    for (int k = 0; k < 20000 && !seen; k++) begin
      @(negedge ref_clk);
      seen = done;
      if (hs) begin
        i++;
        req_valid = i < n;
        req_addr  = a[i % NBLK];
        req_last  = use_last && i == n - 1;
      end
      #1 hs = req_valid && req_ready;
    end
    chk("done seen", 1, seen);
    if (!seen) tally_and_finish();
    repeat (2) @(negedge ref_clk);
    chk("blocks", n, dev.blk_q.size());
    for (int k = 0; k < n; k++) chk("block addr", a[k], dev.blk_q[k]);
    chk("status", exp_status(fail), status_byte);
    chk("failed", fail, failed);
    chk("device mode", 0, dev.st);
    chk("sequence error", 0, dev.seq_err);
  endtask : run_erase
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    run_erase(1, 1'b1, 1'b0);
    run_erase(NBLK, 1'b0, 1'b0);
    run_erase(2, 1'b1, 1'b1);
    for (int r = 0; r < 4; r++) begin
      run_erase(1 + {$random(seed)} % NBLK, 1'b1, 1'($random(seed)));
    end
    req_valid = 1'b1;
    repeat (40) @(negedge ref_clk);
    rst_n     = 1'b0;
    req_valid = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("reset idle", 4'b0111, {busy, fl_ce_n, fl_we_n, dq_oe_n});
    rst_n = 1'b1;
    run_erase(3, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
